// ===== hdl/tmr2_pkg.sv
// package: register map, control fields and shared types of the timer 2 block
package tmr2_pkg;

  // register indices on the plain register port
  localparam logic [2:0] TMR2_ADDR_CONTROL = 3'h0;
  localparam logic [2:0] TMR2_ADDR_COUNTER_LOW = 3'h1;
  localparam logic [2:0] TMR2_ADDR_COUNTER_HIGH = 3'h2;
  localparam logic [2:0] TMR2_ADDR_RELOAD_LOW = 3'h3;
  localparam logic [2:0] TMR2_ADDR_RELOAD_HIGH = 3'h4;

  // timer2_control field positions
  localparam int unsigned TMR2_BIT_OVERFLOW_FLAG = 7;
  localparam int unsigned TMR2_BIT_EXTERNAL_FLAG = 6;
  localparam int unsigned TMR2_BIT_RX_CLOCK_SELECT = 5;
  localparam int unsigned TMR2_BIT_TX_CLOCK_SELECT = 4;
  localparam int unsigned TMR2_BIT_EXTERNAL_ENABLE = 3;
  localparam int unsigned TMR2_BIT_RUN_CONTROL = 2;
  localparam int unsigned TMR2_BIT_COUNTER_SELECT = 1;
  localparam int unsigned TMR2_BIT_CAPTURE_SELECT = 0;

  // reset values and counter maximum
  localparam logic [7:0] TMR2_CONTROL_RESET = 8'h00;
  localparam logic [15:0] TMR2_COUNTER_RESET = 16'h0000;
  localparam logic [15:0] TMR2_RELOAD_RESET = 16'h0000;
  localparam logic [15:0] TMR2_COUNTER_MAX = 16'hFFFF;

  // oscillator cycles per timer increment in timer mode
  localparam int unsigned TMR2_OSC_DIV = 12;
  localparam int unsigned TMR2_PRE_W = 4;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } tmr2_bus_req_type;

  typedef struct packed {
    logic rx_tick;
    logic tx_tick;
    logic overflow;
  } tmr2_serial_type;

endpackage : tmr2_pkg

// ===== hdl/tmr2_edge.sv
// two-flop synchroniser with falling-edge pulse for one pin
`timescale 1ns/100ps
module tmr2_edge (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic pin,
  output logic fall
);

  typedef struct packed {
    logic meta;
    logic sync;
    logic last;
  } tmr2_edge_state_type;

  tmr2_edge_state_type s_r;
  tmr2_edge_state_type s_nxt;

  // stage one feeds stage two only; edge logic looks at later stages
  always_comb begin
    s_nxt = s_r;
    s_nxt.meta = pin;
    s_nxt.sync = s_r.meta;
    s_nxt.last = s_r.sync;
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s_r <= 3'h7;
    end else begin
      s_r <= s_nxt;
    end
  end

  // one pulse per high-to-low step of the synchronised level
  assign fall = s_r.last & ~s_r.sync;

  single_pulse_a: assert property (@(posedge ref_clk) disable iff (reset)
    fall |=> !fall) else $error("edge pulse longer than one cycle");

endmodule : tmr2_edge

// ===== hdl/tmr2_timer.sv
// timer 2: 16-bit timer/counter with capture, auto-reload and baud generation
//
// Behaviour
// - 16-bit counter runs as timer or event counter, chosen by counter_select.
// - run on: serial selects off picks reload or capture; serial select picks baud.
// - capture mode overflow sets overflow_flag regardless of external_enable.
// - capture mode trigger falling edge copies counter into capture/reload pair.
// - auto-reload rollover sets overflow_flag and loads counter from reload pair.
// - auto-reload trigger falling edge forces the reload and sets external_flag.
// - overflow_flag set by hardware, cleared by software, never in baud mode.
// - external_flag set by trigger capture/reload, requests interrupt, software clears.
// - rx_clock_select picks timer 2 overflow as receive clock, else timer 1.
// - tx_clock_select picks timer 2 overflow as transmit clock, else timer 1.
// - external_enable lets trigger edges act unless timer clocks serial port.
// - run_control one starts counting, zero stops it.
// - counter_select zero counts oscillator/12, one counts count pin falling edges.
// - capture_select ignored in baud mode; timer always reloads on overflow.
`timescale 1ns/100ps
module tmr2_timer
  import tmr2_pkg::*;
#(
  parameter int unsigned OSC_DIV = TMR2_OSC_DIV
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire tmr2_bus_req_type bus_req,
  output logic [7:0] reg_rdata,
  input wire logic count_pin,
  input wire logic external_trigger_input,
  input wire logic timer1_overflow,
  output tmr2_serial_type serial_clk,
  output logic timer2_irq
);

  typedef struct packed {
    logic [TMR2_PRE_W-1:0] pre;
    logic [7:0] ctrl;
    logic [15:0] cnt;
    logic [15:0] rcap;
    logic [7:0] rdata;
    logic ovf_pulse;
    logic rx_tick;
    logic tx_tick;
  } tmr2_state_type;

  localparam logic [TMR2_PRE_W-1:0] PRE_LAST = TMR2_PRE_W'(OSC_DIV - 1);

  tmr2_state_type s_r;
  tmr2_state_type s_nxt;

  logic count_fall;
  logic trig_fall;
  logic serial_use;
  logic reload_mode;
  logic tick;
  logic inc;
  logic roll;
  logic trig;
  logic wr_ctrl;

  tmr2_edge count_edge (
    .ref_clk(ref_clk),
    .reset(reset),
    .pin(count_pin),
    .fall(count_fall)
  );

  tmr2_edge trig_edge (
    .ref_clk(ref_clk),
    .reset(reset),
    .pin(external_trigger_input),
    .fall(trig_fall)
  );

  assign serial_use = s_r.ctrl[TMR2_BIT_RX_CLOCK_SELECT] | s_r.ctrl[TMR2_BIT_TX_CLOCK_SELECT];
  // baud mode forces reload whatever capture_select holds
  assign reload_mode = serial_use | ~s_r.ctrl[TMR2_BIT_CAPTURE_SELECT];
  // prescaler free-runs so the oscillator/12 phase does not depend on run_control
  assign tick = (s_r.pre == PRE_LAST);
  assign inc = s_r.ctrl[TMR2_BIT_RUN_CONTROL] &
               (s_r.ctrl[TMR2_BIT_COUNTER_SELECT] ? count_fall : tick);
  assign roll = inc & (s_r.cnt == TMR2_COUNTER_MAX);
  // trigger edges never act while the timer clocks the serial port
  assign trig = trig_fall & s_r.ctrl[TMR2_BIT_EXTERNAL_ENABLE] & ~serial_use;
  assign wr_ctrl = bus_req.wr & (bus_req.addr == TMR2_ADDR_CONTROL);

  always_comb begin
    s_nxt = s_r;
    s_nxt.pre = tick ? '0 : s_r.pre + TMR2_PRE_W'(1);

    // counter path; software writes below take priority over it
    if (roll && reload_mode) begin
      s_nxt.cnt = s_r.rcap;
    end else if (inc) begin
      s_nxt.cnt = s_r.cnt + 16'h0001;
    end
    if (trig && reload_mode) begin
      s_nxt.cnt = s_r.rcap;
    end
    if (trig && !reload_mode) begin
      s_nxt.rcap = s_r.cnt;
    end

    // register writes
    if (bus_req.wr) begin
      if (bus_req.addr == TMR2_ADDR_CONTROL) begin
        s_nxt.ctrl = bus_req.wdata;
      end else if (bus_req.addr == TMR2_ADDR_COUNTER_LOW) begin
        s_nxt.cnt[7:0] = bus_req.wdata;
      end else if (bus_req.addr == TMR2_ADDR_COUNTER_HIGH) begin
        s_nxt.cnt[15:8] = bus_req.wdata;
      end else if (bus_req.addr == TMR2_ADDR_RELOAD_LOW) begin
        s_nxt.rcap[7:0] = bus_req.wdata;
      end else if (bus_req.addr == TMR2_ADDR_RELOAD_HIGH) begin
        s_nxt.rcap[15:8] = bus_req.wdata;
      end
    end

    // flags set after the write so a same-cycle clear loses to the event
    if (roll && !serial_use) begin
      s_nxt.ctrl[TMR2_BIT_OVERFLOW_FLAG] = 1'b1;
    end
    if (trig) begin
      s_nxt.ctrl[TMR2_BIT_EXTERNAL_FLAG] = 1'b1;
    end

    // overflow pulses feed the serial port in every mode
    s_nxt.ovf_pulse = roll;
    s_nxt.rx_tick = s_r.ctrl[TMR2_BIT_RX_CLOCK_SELECT] ? s_r.ovf_pulse : timer1_overflow;
    s_nxt.tx_tick = s_r.ctrl[TMR2_BIT_TX_CLOCK_SELECT] ? s_r.ovf_pulse : timer1_overflow;

    // read data stands only in the cycle after the strobe
    s_nxt.rdata = 8'h00;
    if (bus_req.rd) begin
      if (bus_req.addr == TMR2_ADDR_CONTROL) begin
        s_nxt.rdata = s_r.ctrl;
      end else if (bus_req.addr == TMR2_ADDR_COUNTER_LOW) begin
        s_nxt.rdata = s_r.cnt[7:0];
      end else if (bus_req.addr == TMR2_ADDR_COUNTER_HIGH) begin
        s_nxt.rdata = s_r.cnt[15:8];
      end else if (bus_req.addr == TMR2_ADDR_RELOAD_LOW) begin
        s_nxt.rdata = s_r.rcap[7:0];
      end else if (bus_req.addr == TMR2_ADDR_RELOAD_HIGH) begin
        s_nxt.rdata = s_r.rcap[15:8];
      end else begin
        s_nxt.rdata = 8'h00;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s_r.pre <= '0;
      s_r.ctrl <= TMR2_CONTROL_RESET;
      s_r.cnt <= TMR2_COUNTER_RESET;
      s_r.rcap <= TMR2_RELOAD_RESET;
      s_r.rdata <= 8'h00;
      s_r.ovf_pulse <= 1'b0;
      s_r.rx_tick <= 1'b0;
      s_r.tx_tick <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign reg_rdata = s_r.rdata;
  assign serial_clk.rx_tick = s_r.rx_tick;
  assign serial_clk.tx_tick = s_r.tx_tick;
  assign serial_clk.overflow = s_r.ovf_pulse;
  // request level only; the enable lives in the interrupt controller
  assign timer2_irq = s_r.ctrl[TMR2_BIT_OVERFLOW_FLAG] |
                      s_r.ctrl[TMR2_BIT_EXTERNAL_FLAG];

  overflow_flag_set_a: assert property (@(posedge ref_clk) disable iff (reset)
    (roll && !serial_use)
      |=> s_r.ctrl[TMR2_BIT_OVERFLOW_FLAG] && timer2_irq)
    else $error("rollover did not raise overflow flag");

  reload_on_roll_a: assert property (@(posedge ref_clk) disable iff (reset)
    (roll && reload_mode && !bus_req.wr)
      |=> s_r.cnt == $past(s_r.rcap))
    else $error("counter not reloaded on rollover");

  capture_copy_a: assert property (@(posedge ref_clk) disable iff (reset)
    (trig && !reload_mode && !bus_req.wr)
      |=> s_r.rcap == $past(s_r.cnt))
    else $error("trigger did not capture counter");

  trig_reload_a: assert property (@(posedge ref_clk) disable iff (reset)
    (trig && reload_mode && !bus_req.wr)
      |=> s_r.cnt == $past(s_r.rcap))
    else $error("trigger did not force reload");

  ext_flag_set_a: assert property (@(posedge ref_clk) disable iff (reset)
    trig
      |=> s_r.ctrl[TMR2_BIT_EXTERNAL_FLAG] && timer2_irq)
    else $error("trigger did not set external flag");

  no_baud_flag_a: assert property (@(posedge ref_clk) disable iff (reset)
    (serial_use && !wr_ctrl && !s_r.ctrl[TMR2_BIT_OVERFLOW_FLAG])
      |=> !s_r.ctrl[TMR2_BIT_OVERFLOW_FLAG])
    else $error("overflow flag set in baud mode");

  flag_sticky_a: assert property (@(posedge ref_clk) disable iff (reset)
    (s_r.ctrl[TMR2_BIT_OVERFLOW_FLAG] && !wr_ctrl)
      |=> s_r.ctrl[TMR2_BIT_OVERFLOW_FLAG])
    else $error("overflow flag cleared without a write");

  trig_ignored_a: assert property (@(posedge ref_clk) disable iff (reset)
    (trig_fall && (!s_r.ctrl[TMR2_BIT_EXTERNAL_ENABLE] || serial_use) && !bus_req.wr)
      |=> s_r.rcap == $past(s_r.rcap) &&
          s_r.ctrl[TMR2_BIT_EXTERNAL_FLAG] == $past(s_r.ctrl[TMR2_BIT_EXTERNAL_FLAG]))
    else $error("trigger acted while disabled");

  stopped_hold_a: assert property (@(posedge ref_clk) disable iff (reset)
    (!s_r.ctrl[TMR2_BIT_RUN_CONTROL] && !trig && !bus_req.wr)
      |=> $stable(s_r.cnt))
    else $error("counter moved while stopped");

  timer_rate_a: assert property (@(posedge ref_clk) disable iff (reset)
    tick
      |=> !tick && (s_r.pre == '0))
    else $error("prescaler ticks too often");

  event_count_a: assert property (@(posedge ref_clk) disable iff (reset)
    (s_r.ctrl[TMR2_BIT_COUNTER_SELECT] && s_r.ctrl[TMR2_BIT_RUN_CONTROL] && !count_fall
      && !trig && !bus_req.wr) |=> $stable(s_r.cnt))
    else $error("counter moved without a count edge");

  rx_source_a: assert property (@(posedge ref_clk) disable iff (reset)
    (roll && s_r.ctrl[TMR2_BIT_RX_CLOCK_SELECT] && !wr_ctrl)
      |=> ##1 serial_clk.rx_tick)
    else $error("receive clock missed timer 2 overflow");

  tx_source_a: assert property (@(posedge ref_clk) disable iff (reset)
    (roll && s_r.ctrl[TMR2_BIT_TX_CLOCK_SELECT] && !wr_ctrl)
      |=> ##1 serial_clk.tx_tick)
    else $error("transmit clock missed timer 2 overflow");

  baud_reload_a: assert property (@(posedge ref_clk) disable iff (reset)
    (roll && serial_use && s_r.ctrl[TMR2_BIT_CAPTURE_SELECT] && !bus_req.wr)
      |=> s_r.cnt == $past(s_r.rcap))
    else $error("baud mode did not reload");

  capture_roll_a: assert property (@(posedge ref_clk) disable iff (reset)
    (roll && !reload_mode && !bus_req.wr && !trig)
      |=> s_r.cnt == 16'h0000)
    else $error("capture mode did not roll to zero");

  ctrl_write_a: assert property (@(posedge ref_clk) disable iff (reset)
    wr_ctrl
      |=> s_r.ctrl[5:0] == $past(bus_req.wdata[5:0]))
    else $error("control write not stored");

  timer_inc_a: assert property (@(posedge ref_clk) disable iff (reset)
    (s_r.ctrl[TMR2_BIT_RUN_CONTROL] && !s_r.ctrl[TMR2_BIT_COUNTER_SELECT] && tick
      && !roll && !trig && !bus_req.wr) |=> s_r.cnt == $past(s_r.cnt) + 16'h0001)
    else $error("timer mode missed an increment");

  count_inc_a: assert property (@(posedge ref_clk) disable iff (reset)
    (s_r.ctrl[TMR2_BIT_RUN_CONTROL] && s_r.ctrl[TMR2_BIT_COUNTER_SELECT] && count_fall
      && !roll && !trig && !bus_req.wr) |=> s_r.cnt == $past(s_r.cnt) + 16'h0001)
    else $error("counter mode missed a count edge");

  ext_flag_sticky_a: assert property (@(posedge ref_clk) disable iff (reset)
    (s_r.ctrl[TMR2_BIT_EXTERNAL_FLAG] && !wr_ctrl)
      |=> s_r.ctrl[TMR2_BIT_EXTERNAL_FLAG])
    else $error("external flag cleared without a write");

  ext_flag_quiet_a: assert property (@(posedge ref_clk) disable iff (reset)
    (!trig && !wr_ctrl && !s_r.ctrl[TMR2_BIT_EXTERNAL_FLAG])
      |=> !s_r.ctrl[TMR2_BIT_EXTERNAL_FLAG])
    else $error("external flag set without a trigger");

  ovf_flag_quiet_a: assert property (@(posedge ref_clk) disable iff (reset)
    (!roll && !wr_ctrl && !s_r.ctrl[TMR2_BIT_OVERFLOW_FLAG])
      |=> !s_r.ctrl[TMR2_BIT_OVERFLOW_FLAG])
    else $error("overflow flag set without a rollover");

  flag_clear_a: assert property (@(posedge ref_clk) disable iff (reset)
    (wr_ctrl && bus_req.wdata[7:6] == 2'b00 && !roll && !trig)
      |=> !timer2_irq)
    else $error("software clear of flags failed");

  rx_timer1_a: assert property (@(posedge ref_clk) disable iff (reset)
    (!s_r.ctrl[TMR2_BIT_RX_CLOCK_SELECT] && timer1_overflow)
      |=> serial_clk.rx_tick)
    else $error("receive clock missed timer 1 overflow");

  tx_timer1_a: assert property (@(posedge ref_clk) disable iff (reset)
    (!s_r.ctrl[TMR2_BIT_TX_CLOCK_SELECT] && timer1_overflow)
      |=> serial_clk.tx_tick)
    else $error("transmit clock missed timer 1 overflow");

  ovf_pulse_a: assert property (@(posedge ref_clk) disable iff (reset)
    roll
      |=> serial_clk.overflow)
    else $error("rollover gave no overflow pulse");

  ovf_quiet_a: assert property (@(posedge ref_clk) disable iff (reset)
    !roll
      |=> !serial_clk.overflow)
    else $error("overflow pulse without a rollover");

  rcap_write_a: assert property (@(posedge ref_clk) disable iff (reset)
    (bus_req.wr && bus_req.addr == TMR2_ADDR_RELOAD_LOW)
      |=> s_r.rcap[7:0] == $past(bus_req.wdata))
    else $error("reload low byte not preset");

  rcap_hold_a: assert property (@(posedge ref_clk) disable iff (reset)
    (!bus_req.wr && !(trig && !reload_mode))
      |=> $stable(s_r.rcap))
    else $error("reload pair changed without cause");

endmodule : tmr2_timer

// ===== testbench/tmr2_serial_model.sv
// partner model: serial port tick counters and a timer 1 overflow source
`timescale 1ns/100ps
module tmr2_serial_model
  import tmr2_pkg::*;
#(
  parameter int unsigned T1_PERIOD = 8
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire tmr2_serial_type serial_clk,
  output logic timer1_overflow,
  output logic [15:0] rx_count,
  output logic [15:0] tx_count
);
  logic [7:0] div_r;
  // timer 1 reduced to a free-running one-cycle pulse, enough for clock selection
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      div_r <= 8'h00;
      timer1_overflow <= 1'b0;
      rx_count <= 16'h0000;
      tx_count <= 16'h0000;
    end else begin
      div_r <= (div_r == 8'(T1_PERIOD - 1)) ? 8'h00 : div_r + 8'h01;
      timer1_overflow <= (div_r == 8'(T1_PERIOD - 1));
      rx_count <= rx_count + 16'(serial_clk.rx_tick);
      tx_count <= tx_count + 16'(serial_clk.tx_tick);
    end
  end
endmodule : tmr2_serial_model

// ===== testbench/tmr2_timer_tb_top.sv
// self-checking bench for the timer 2 block
`timescale 1ns/100ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin failures++; \
  $display("MISMATCH %0t got %h exp %h", $time, (a), (b)); end end
module tmr2_timer_tb_top
  import tmr2_pkg::*;
;
  typedef struct packed {
    logic [2:0] a;
    logic [7:0] d;
    logic [7:0] e;
  } tmr2_row_type;
  logic ref_clk;
  logic reset;
  tmr2_bus_req_type bus_req;
  logic [7:0] reg_rdata;
  logic count_pin;
  logic ext_trig;
  logic timer1_overflow;
  tmr2_serial_type serial_clk;
  logic timer2_irq;
  logic [15:0] rx_count;
  logic [15:0] tx_count;
  logic [15:0] rx0;
  logic [15:0] tx0;
  int failures = 0;
  int check_count = 0;
  int cycles = 0;
  // unmapped indices must read back zero
  tmr2_row_type rows [7] = '{'{3'h3, 8'hA5, 8'hA5}, '{3'h4, 8'h5A, 8'h5A},
    '{3'h1, 8'hFE, 8'hFE}, '{3'h2, 8'hFF, 8'hFF}, '{3'h5, 8'h77, 8'h00},
    '{3'h7, 8'h11, 8'h00}, '{3'h0, 8'h08, 8'h08}};

  tmr2_timer #(.OSC_DIV(3)) u_dut (.ref_clk(ref_clk), .reset(reset), .bus_req(bus_req),
    .reg_rdata(reg_rdata), .count_pin(count_pin), .external_trigger_input(ext_trig),
    .timer1_overflow(timer1_overflow), .serial_clk(serial_clk), .timer2_irq(timer2_irq));
  tmr2_serial_model #(.T1_PERIOD(8)) u_far (.ref_clk(ref_clk), .reset(reset),
    .serial_clk(serial_clk), .timer1_overflow(timer1_overflow), .rx_count(rx_count),
    .tx_count(tx_count));

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : stop_test

  // ceiling well above the few hundred cycles the sequence needs
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      stop_test();
    end
  end

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    bus_req.addr <= a;
    bus_req.wdata <= d;
    bus_req.wr <= 1'b1;
    @(posedge ref_clk);
    bus_req.wr <= 1'b0;
  endtask : wr

  task automatic rd_chk(input logic [2:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    bus_req.addr <= a;
    bus_req.rd <= 1'b1;
    @(posedge ref_clk);
    bus_req.rd <= 1'b0;
    #1 `CHK(reg_rdata, e)
  endtask : rd_chk

  // pins stay low and high well past the synchroniser depth
  task automatic pulse_pin(input bit trig);
    @(posedge ref_clk);
    if (trig) ext_trig <= 1'b0;
    else count_pin <= 1'b0;
    repeat (6) @(posedge ref_clk);
    ext_trig <= 1'b1;
    count_pin <= 1'b1;
    repeat (6) @(posedge ref_clk);
  endtask : pulse_pin

  // look a little after each edge so the pulse is read where it has settled
  task automatic wait_ovf();
    int n;
    #1;
    for (n = 0; n < 100 && serial_clk.overflow !== 1'b1; n++) begin
      @(posedge ref_clk);
      #1;
    end
    `CHK(serial_clk.overflow, 1'b1)
  endtask : wait_ovf

  initial begin
    bus_req = '0;
    count_pin = 1'b1;
    ext_trig = 1'b1;
    reset = 1'b1;
    repeat (16) @(posedge ref_clk);
    reset <= 1'b0;
    for (int i = 0; i < 5; i++) rd_chk(3'(i), 8'h00);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd_chk(rows[i].a, rows[i].e);
    end
    wr(3'h3, 8'h34);
    wr(3'h4, 8'h12);
    wr(3'h1, 8'hFE);
    wr(3'h2, 8'hFF);
    wr(3'h0, 8'h04);
    wait_ovf();
    rd_chk(3'h2, 8'h12);
    rd_chk(3'h0, 8'h84);
    `CHK(timer2_irq, 1'b1)
    wr(3'h0, 8'h00);
    rd_chk(3'h0, 8'h00);
    wr(3'h1, 8'hCD);
    wr(3'h2, 8'hAB);
    wr(3'h0, 8'h09);
    pulse_pin(1'b1);
    rd_chk(3'h3, 8'hCD);
    rd_chk(3'h4, 8'hAB);
    rd_chk(3'h0, 8'h49);
    wr(3'h1, 8'h00);
    wr(3'h2, 8'h00);
    wr(3'h0, 8'h08);
    pulse_pin(1'b1);
    rd_chk(3'h2, 8'hAB);
    rd_chk(3'h0, 8'h48);
    wr(3'h0, 8'h00);
    wr(3'h2, 8'h00);
    pulse_pin(1'b1);
    rd_chk(3'h2, 8'h00);
    rd_chk(3'h0, 8'h00);
    wr(3'h3, 8'hF0);
    wr(3'h4, 8'hFF);
    wr(3'h1, 8'hFE);
    wr(3'h2, 8'hFF);
    wr(3'h0, 8'h3D);
    rx0 = rx_count;
    tx0 = tx_count;
    repeat (200) @(posedge ref_clk);
    `CHK((rx_count - rx0) inside {[3:5]}, 1'b1)
    `CHK(tx_count - tx0, rx_count - rx0)
    pulse_pin(1'b1);
    rd_chk(3'h2, 8'hFF);
    rd_chk(3'h0, 8'h3D);
    wr(3'h0, 8'h00);
    rx0 = rx_count;
    tx0 = tx_count;
    repeat (80) @(posedge ref_clk);
    `CHK((rx_count - rx0) inside {[9:11]}, 1'b1)
    `CHK((tx_count - tx0) inside {[9:11]}, 1'b1)
    wr(3'h1, 8'h00);
    wr(3'h2, 8'h00);
    wr(3'h0, 8'h06);
    repeat (5) pulse_pin(1'b0);
    rd_chk(3'h1, 8'h05);
    wr(3'h0, 8'h02);
    pulse_pin(1'b0);
    rd_chk(3'h1, 8'h05);
    wr(3'h1, 8'hFE);
    wr(3'h2, 8'hFF);
    wr(3'h0, 8'h05);
    wait_ovf();
    rd_chk(3'h2, 8'h00);
    rd_chk(3'h0, 8'h85);
    stop_test();
  end
endmodule : tmr2_timer_tb_top
